// *** core/amta_pkg.sv ***
package amta_pkg;

	// ****************************************
	// Table geometry and entry layout
	// ****************************************
	localparam int ENTRY_AW = 12; // Entry pointer width, 4096 entries.
	localparam int WORD_AW = 14; // Table word address width.
	localparam logic [1:0] WORD_FIRST = 2'h0; // First word of an entry.
	localparam logic [1:0] WORD_AGE = 2'h2; // Third word, age index.
	localparam logic [15:0] WIPE_VALUE = 16'h0000; // Unused entry mark.
	localparam int IDX_HI = 15; // Age index top bit in the third word.
	localparam int IDX_LO = 8; // Age index low bit in the third word.
	localparam int FLAG_HI = 13; // Entry flag top bit in the first word.
	localparam int FLAG_LO = 12; // Entry flag low bit in the first word.
	localparam logic [7:0] IDX_AGED = 8'h00; // Index of a freed entry.
	localparam logic [7:0] IDX_LAST = 8'h01; // Index one step from aged.
	localparam logic [7:0] IDX_ALIVE_MAX = 8'hC0; // Top alive index.
	localparam logic [7:0] IDX_RELOAD = 8'hBF; // Index after a hit.
	localparam logic [1:0] FLAG_AGED = 2'h0; // Entry is free.
	localparam logic [1:0] FLAG_ALIVE = 2'h1; // Entry is in use.
	localparam logic [1:0] FLAG_STATIC = 2'h3; // Entry is static.

	// ****************************************
	// Register map
	// ****************************************
	localparam int AXI_AW = 8; // Register byte address width.
	localparam logic [7:0] OFS_CTRL = 8'h00; // Control register.
	localparam logic [7:0] OFS_PERIOD = 8'h04; // Age period register.
	localparam logic [7:0] OFS_STATUS = 8'h08; // Status register.
	localparam int CTRL_LAUNCH_BIT = 0; // Write one to restart format.
	localparam int CTRL_AGE_EN_BIT = 3; // Aging enable.
	localparam int CTRL_RUN_BIT = 7; // Low aborts the format pass.
	localparam logic [7:0] CTRL_RST = 8'h88; // Run and aging enabled.
	localparam int PERIOD_W = 20; // Age period counter width.
	localparam logic [19:0] PERIOD_RST = 20'h0012C; // Default period.
	localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay answer.
	localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI error answer.

	// ****************************************
	// Timing
	// ****************************************
	localparam int PRESC_W = 5; // Time base prescaler width.
	localparam int CLK_PERIOD_NS = 8; // System clock period.
	localparam int TICK_WIDTH_NS = 120; // Aging trigger pulse width.
	localparam int TICK_CYC =
		(TICK_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_CW = $clog2(TICK_CYC + 1); // Pulse count width.

	// ****************************************
	// State machines
	// ****************************************
	typedef enum logic [2:0] {
		INIT_IDLE = 3'h0,
		INIT_FORMAT = 3'h1,
		INIT_WIPE = 3'h3,
		INIT_CHECK = 3'h2,
		INIT_DEC = 3'h6
	} amta_init_t;

	typedef enum logic [2:0] {
		AGE_IDLE = 3'h0,
		AGE_FETCH = 3'h1,
		AGE_CHECK = 3'h3,
		AGE_STORE = 3'h2,
		AGE_FLAG_FETCH = 3'h6,
		AGE_FLAG_STORE = 3'h7,
		AGE_DEC = 3'h5
	} amta_age_t;

endpackage

// *** core/amta_top.sv ***
`timescale 1ns/100ps

// Function
// - Format writes 0000H into each first word.
// - Each entry spans four words, 64 bits.
// - Format walks from top entry down.
// - Run bit low aborts format; only launch wins over it.
// - Software launch restarts the format pass.
// - Hardware reset enters format automatically.
// - Wipe state requests grant, writes zero.
// - After the last entry's wipe, format goes idle.
// - Pointer decrement then wipe next entry.
// - Hardware aging frees stale entries.
// - Trigger pulse is 120 ns wide.
// - Five bit prescaler makes the time base.
// - Twenty bit counter reloads, fires at one.
// - A trigger in idle, outside a format pass, decrements each alive entry index.
// - Enable low stops timer and new passes; hits still reload.
// - Aging leaves idle only on enabled trigger or waiting hit.
// - Index fetch reads third word after grant.
// - Classify alive, aged, static; skip non-alive.
// - Index store writes index minus one.
// - Flag codes: 1 alive, 0 aged, 3 static.
// - On 01H to 00H, read then clear flag.
// - Matching hit reloads index to BFH.
module amta_top
	import amta_pkg::*;
#(
	parameter int PRESC_BITS = PRESC_W, // Prescaler width.
	parameter logic [19:0] AGE_PERIOD_DEFAULT = PERIOD_RST // Reset period.
) (
	input wire logic ref_clk, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [AXI_AW-1:0] s_axi_awaddr, // Write byte address.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	output logic s_axi_bvalid, // Write answer valid.
	input wire logic s_axi_bready, // Write answer ready.
	output logic [1:0] s_axi_bresp, // Write answer code.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	input wire logic [AXI_AW-1:0] s_axi_araddr, // Read byte address.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read answer code.
	output logic mem_req, // Table access request.
	output logic mem_we, // Request is a write.
	output logic [WORD_AW-1:0] mem_addr, // Table word address.
	output logic [15:0] mem_wdata, // Table write data.
	input wire logic mem_grant, // Access done this cycle.
	input wire logic [15:0] mem_rdata, // Read word, valid on grant.
	input wire logic hit_valid, // One-cycle matching hit.
	input wire logic [ENTRY_AW-1:0] hit_entry, // Entry that was hit.
	output logic age_tick_pulse // Aging trigger pulse.
);

	// ****************************************
	// Register bus slave
	// ****************************************
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic aw_got_reg, w_got_reg; // Address or data held.
	logic [AXI_AW-1:0] wr_addr_reg; // Held write address.
	logic [31:0] wr_data_reg; // Held write data.
	logic [3:0] wr_strb_reg; // Held write strobes.
	logic [1:0] bresp_reg, rresp_reg; // Answer codes.
	logic [31:0] rdata_reg; // Read answer data.
	logic [7:0] ctrl_reg; // Control register.
	logic [PERIOD_W-1:0] period_reg; // Age period register.

	// Handshakes and the write that fires once both halves are held.
	wire aw_hs = s_axi_awvalid & awready_reg;
	wire w_hs = s_axi_wvalid & wready_reg;
	wire ar_hs = s_axi_arvalid & arready_reg;
	wire wr_do = aw_got_reg & w_got_reg;
	wire aw_got_next = (aw_got_reg | aw_hs) & ~wr_do;
	wire w_got_next = (w_got_reg | w_hs) & ~wr_do;
	wire bvalid_next = wr_do | (bvalid_reg & ~s_axi_bready);
	wire rvalid_next = ar_hs | (rvalid_reg & ~s_axi_rready);

	// Address decode for both directions.
	wire wr_ctrl = wr_do & (wr_addr_reg == OFS_CTRL);
	wire wr_period = wr_do & (wr_addr_reg == OFS_PERIOD);
	wire wr_status = wr_addr_reg == OFS_STATUS;
	wire wr_mapped = (wr_addr_reg == OFS_CTRL) | (wr_addr_reg == OFS_PERIOD)
		| wr_status;
	wire rd_mapped = (s_axi_araddr == OFS_CTRL)
		| (s_axi_araddr == OFS_PERIOD) | (s_axi_araddr == OFS_STATUS);

	// Byte-lane merge of the period register, one lane per loop pass.
	wire [23:0] period_wide = {4'h0, period_reg};
	wire [23:0] period_merge;
	genvar gb;
	generate
		for (gb = 0; gb < 3; gb++) begin : g_lane
			assign period_merge[gb*8 +: 8] = wr_strb_reg[gb] ?
				wr_data_reg[gb*8 +: 8] : period_wide[gb*8 +: 8];
		end
	endgenerate

	// Control byte after a write; the launch bit never stays set.
	wire [7:0] ctrl_written = wr_data_reg[7:0] & ~(8'h01 << CTRL_LAUNCH_BIT);
	wire launch = wr_ctrl & wr_strb_reg[0] & wr_data_reg[CTRL_LAUNCH_BIT]
		& wr_data_reg[CTRL_RUN_BIT];
	wire ctrl_run = ctrl_reg[CTRL_RUN_BIT]; // Format may proceed.
	wire aging_allowed = ctrl_reg[CTRL_AGE_EN_BIT]; // Aging enabled.

	// Write channel handshake and response.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			bvalid_reg <= bvalid_next;
			awready_reg <= ~aw_got_next & ~bvalid_next;
			wready_reg <= ~w_got_next & ~bvalid_next;
			if (wr_do) begin
				bresp_reg <= (wr_mapped & ~wr_status) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Capture of the write address and data halves.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_addr_reg <= '0;
			wr_data_reg <= '0;
			wr_strb_reg <= '0;
		end else begin
			if (aw_hs) begin
				wr_addr_reg <= s_axi_awaddr;
			end
			if (w_hs) begin
				wr_data_reg <= s_axi_wdata;
				wr_strb_reg <= s_axi_wstrb;
			end
		end
	end

	// Software-written registers.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_reg <= CTRL_RST;
			period_reg <= AGE_PERIOD_DEFAULT;
		end else begin
			if (wr_ctrl & wr_strb_reg[0]) begin
				ctrl_reg <= ctrl_written;
			end
			if (wr_period) begin
				period_reg <= period_merge[PERIOD_W-1:0];
			end
		end
	end

	// ****************************************
	// Age timer
	// ****************************************
	logic [PRESC_BITS-1:0] presc_reg; // Time base prescaler.
	logic [PERIOD_W-1:0] timer_reg; // Period down counter.
	logic [TICK_CW-1:0] tick_left_reg; // Pulse cycles still to go.
	logic tick_pulse_reg; // Aging trigger output.

	// Time base strobe and the trigger that fires at a count of one or less.
	wire time_base = &presc_reg;
	wire tick_fire = aging_allowed & time_base
		& (timer_reg <= PERIOD_W'(1));

	// Prescaler and period counter; prescaler cleared and counter reloaded while aging is off.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			presc_reg <= '0;
			timer_reg <= PERIOD_RST;
		end else if (!aging_allowed) begin
			presc_reg <= '0;
			timer_reg <= period_reg;
		end else begin
			presc_reg <= PRESC_BITS'(presc_reg + 1'b1);
			if (tick_fire) begin
				timer_reg <= period_reg;
			end else if (time_base) begin
				timer_reg <= PERIOD_W'(timer_reg - 1'b1);
			end
		end
	end

	// Stretch each trigger to the full pulse width.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tick_left_reg <= '0;
			tick_pulse_reg <= 1'b0;
		end else if (tick_fire) begin
			tick_left_reg <= TICK_CW'(TICK_CYC - 1);
			tick_pulse_reg <= 1'b1;
		end else if (tick_left_reg != '0) begin
			tick_left_reg <= TICK_CW'(tick_left_reg - 1'b1);
		end else begin
			tick_pulse_reg <= 1'b0;
		end
	end

	// ****************************************
	// Format state machine
	// ****************************************
	amta_init_t init_state, init_next; // Format machine state.
	logic [ENTRY_AW-1:0] init_ptr_reg; // Entry being wiped.
	logic mem_req_reg; // Request output register.
	wire granted = mem_req_reg & mem_grant; // Access completed.
	wire init_busy = init_state != INIT_IDLE; // Format owns the table.

	// Next state; launch, then abort, override the walk.
	always_comb begin
		init_next = init_state;
		unique case (init_state)
			INIT_IDLE: init_next = INIT_IDLE;
			INIT_FORMAT: init_next = INIT_WIPE;
			INIT_WIPE: begin
				if (granted) begin
					init_next = INIT_CHECK;
				end
			end
			INIT_CHECK: begin
				init_next = (init_ptr_reg == '0) ? INIT_IDLE : INIT_DEC;
			end
			INIT_DEC: init_next = INIT_WIPE;
		endcase
		if (launch) begin
			init_next = INIT_FORMAT;
		end else if (!ctrl_run) begin
			init_next = INIT_IDLE;
		end
	end

	// State and pointer registers; reset starts a format pass.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			init_state <= INIT_FORMAT;
			init_ptr_reg <= '1;
		end else begin
			init_state <= init_next;
			if (init_next == INIT_FORMAT) begin
				init_ptr_reg <= '1;
			end else if (init_state == INIT_DEC) begin
				init_ptr_reg <= ENTRY_AW'(init_ptr_reg - 1'b1);
			end
		end
	end

	// ****************************************
	// Aging state machine
	// ****************************************
	amta_age_t age_state, age_next; // Aging machine state.
	logic [ENTRY_AW-1:0] age_ptr_reg; // Entry being aged.
	logic [15:0] word_reg; // Word read on the last grant.
	logic refresh_reg; // Current job is a hit reload.
	logic refresh_pend_reg; // A hit waits for service.
	logic [ENTRY_AW-1:0] refresh_ptr_reg; // Entry of the waiting hit.

	// Fields of the fetched word and the entry class.
	wire [7:0] age_idx = word_reg[IDX_HI:IDX_LO];
	wire alive = (age_idx != IDX_AGED) & (age_idx <= IDX_ALIVE_MAX);
	wire [7:0] idx_new = refresh_reg ? IDX_RELOAD
		: 8'(age_idx - 1'b1);
	wire pass_start = (age_state == AGE_IDLE) & aging_allowed & tick_fire;

	// Next state; a format pass sends aging back to idle.
	always_comb begin
		age_next = age_state;
		unique case (age_state)
			AGE_IDLE: begin
				if (pass_start | refresh_pend_reg) begin
					age_next = AGE_FETCH;
				end
			end
			AGE_FETCH: begin
				if (granted) begin
					age_next = AGE_CHECK;
				end
			end
			AGE_CHECK: begin
				age_next = (alive | refresh_reg) ? AGE_STORE : AGE_DEC;
			end
			AGE_STORE: begin
				if (granted & refresh_reg) begin
					age_next = AGE_IDLE;
				end else if (granted & (age_idx == IDX_LAST)) begin
					age_next = AGE_FLAG_FETCH;
				end else if (granted) begin
					age_next = AGE_DEC;
				end
			end
			AGE_FLAG_FETCH: begin
				if (granted) begin
					age_next = AGE_FLAG_STORE;
				end
			end
			AGE_FLAG_STORE: begin
				if (granted) begin
					age_next = AGE_DEC;
				end
			end
			AGE_DEC: begin
				age_next = (age_ptr_reg == '0) ? AGE_IDLE : AGE_FETCH;
			end
		endcase
		if (init_busy) begin
			age_next = AGE_IDLE;
		end
	end

	// State, pointer and fetched word.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			age_state <= AGE_IDLE;
			age_ptr_reg <= '1;
			refresh_reg <= 1'b0;
			word_reg <= '0;
		end else begin
			age_state <= age_next;
			if ((age_state == AGE_IDLE) & (age_next == AGE_FETCH)) begin
				refresh_reg <= ~pass_start;
				age_ptr_reg <= pass_start ? '1 : refresh_ptr_reg;
			end else if (age_state == AGE_DEC) begin
				age_ptr_reg <= ENTRY_AW'(age_ptr_reg - 1'b1);
			end
			if (granted & ~mem_we) begin
				word_reg <= mem_rdata;
			end
		end
	end

	// Waiting hit, cleared when its job starts, so that a hit arriving
	// while that job runs is kept; a new hit wins over the clear.
	wire refresh_take = (age_state == AGE_IDLE) & (age_next == AGE_FETCH)
		& ~pass_start;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			refresh_pend_reg <= 1'b0;
			refresh_ptr_reg <= '0;
		end else if (hit_valid) begin
			refresh_pend_reg <= 1'b1;
			refresh_ptr_reg <= hit_entry;
		end else if (refresh_take) begin
			refresh_pend_reg <= 1'b0;
		end
	end

	// ****************************************
	// Table access port
	// ****************************************
	logic mem_we_reg; // Write output register.
	logic [WORD_AW-1:0] mem_addr_reg; // Address output register.
	logic [15:0] mem_wdata_reg; // Data output register.

	// Which state wants the table, and what it asks for.
	wire age_rd = (age_state == AGE_FETCH) | (age_state == AGE_FLAG_FETCH);
	wire age_wr = (age_state == AGE_STORE) | (age_state == AGE_FLAG_STORE);
	wire want = (init_state == INIT_WIPE) | (~init_busy & (age_rd | age_wr));
	wire [1:0] age_word = ((age_state == AGE_FETCH) |
		(age_state == AGE_STORE)) ? WORD_AGE : WORD_FIRST;
	wire [15:0] flag_word = {word_reg[15:FLAG_HI+1], FLAG_AGED,
		word_reg[FLAG_LO-1:0]};
	wire [15:0] age_data = (age_state == AGE_STORE) ?
		{idx_new, word_reg[IDX_LO-1:0]} : flag_word;
	wire [WORD_AW-1:0] req_addr = (init_state == INIT_WIPE) ?
		{init_ptr_reg, WORD_FIRST} : {age_ptr_reg, age_word};
	wire [15:0] req_data = (init_state == INIT_WIPE) ?
		WIPE_VALUE : age_data;

	// Raise a request once per state, drop it on grant or cancel.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mem_req_reg <= 1'b0;
			mem_we_reg <= 1'b0;
			mem_addr_reg <= '0;
			mem_wdata_reg <= '0;
		end else if (granted | ~want) begin
			mem_req_reg <= 1'b0;
		end else if (~mem_req_reg) begin
			mem_req_reg <= 1'b1;
			mem_we_reg <= (init_state == INIT_WIPE) | age_wr;
			mem_addr_reg <= req_addr;
			mem_wdata_reg <= req_data;
		end
	end

	// ****************************************
	// Register read path
	// ****************************************
	wire [31:0] status_word = {29'h0, refresh_pend_reg,
		age_state != AGE_IDLE, init_busy};
	wire [31:0] rd_word = (s_axi_araddr == OFS_CTRL) ? {24'h0, ctrl_reg}
		: (s_axi_araddr == OFS_PERIOD) ? {12'h0, period_reg}
		: (s_axi_araddr == OFS_STATUS) ? status_word : 32'h0;

	// Read channel handshake and data capture.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			arready_reg <= ~rvalid_next;
			if (ar_hs) begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Outputs straight from their registers.
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign mem_req = mem_req_reg;
	assign mem_we = mem_we_reg;
	assign mem_addr = mem_addr_reg;
	assign mem_wdata = mem_wdata_reg;
	assign age_tick_pulse = tick_pulse_reg;

	// ****************************************
	// Checks
	// ****************************************
	logic [TICK_CW-1:0] tick_len_reg; // High cycles of the pulse.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tick_len_reg <= '0;
		end else begin
			tick_len_reg <= tick_pulse_reg ? TICK_CW'(tick_len_reg + 1'b1) : '0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	reset_format_a: assert property ($fell(rst) |->
		init_state == INIT_FORMAT) else $error("no format after reset");
	wipe_zero_a: assert property ((init_state == INIT_WIPE && mem_req_reg)
		|-> mem_we_reg && mem_wdata_reg == WIPE_VALUE
		&& mem_addr_reg == {init_ptr_reg, WORD_FIRST})
		else $error("wipe write wrong");
	abort_idle_a: assert property ((!ctrl_run && !launch)
		|=> init_state == INIT_IDLE) else $error("abort ignored");
	ptr_down_a: assert property ((init_state == INIT_DEC && ctrl_run
		&& !launch) |=> init_ptr_reg == $past(init_ptr_reg) - 1'b1
		&& init_state == INIT_WIPE) else $error("pointer not stepped down");
	last_idle_a: assert property ((init_state == INIT_CHECK
		&& init_ptr_reg == '0 && !launch) |=> init_state == INIT_IDLE)
		else $error("last entry not idle");
	tick_width_a: assert property ($fell(tick_pulse_reg) |->
		tick_len_reg == TICK_CW'(TICK_CYC)) else $error("pulse width wrong");
	timer_hold_a: assert property ((!aging_allowed && !tick_pulse_reg)
		|=> presc_reg == '0 && !tick_pulse_reg) else $error("timer runs");
	age_stay_a: assert property ((age_state == AGE_IDLE && !pass_start
		&& !refresh_pend_reg) |=> age_state == AGE_IDLE)
		else $error("aging left idle");
	index_dec_a: assert property ((age_state == AGE_STORE && mem_req_reg
		&& !refresh_reg) |-> mem_wdata_reg[IDX_HI:IDX_LO] == age_idx - 1'b1)
		else $error("index not decremented");
	skip_dead_a: assert property ((age_state == AGE_CHECK && !refresh_reg
		&& !alive && !init_busy) |=> age_state == AGE_DEC)
		else $error("non-alive entry updated");
	flag_clear_a: assert property ((age_state == AGE_FLAG_STORE
		&& mem_req_reg) |-> mem_wdata_reg == flag_word && mem_we_reg)
		else $error("flag write wrong");
	pass_end_a: assert property ((age_state == AGE_DEC && age_ptr_reg == '0)
		|=> age_state == AGE_IDLE) else $error("pass did not end");

endmodule

// *** test/amta_bmu_model.sv ***
`timescale 1ns/100ps
// Table memory behind the buffer manager, with grant pacing.
module amta_bmu_model
	import amta_pkg::*;
(
	input wire logic ref_clk, // Clock.
	input wire logic rst, // Reset.
	input wire logic mem_req, // Access request.
	input wire logic mem_we, // Write access.
	input wire logic [WORD_AW-1:0] mem_addr, // Word address.
	input wire logic [15:0] mem_wdata, // Write data.
	input wire logic slow, // Stretch each grant.
	output logic mem_grant, // Access done.
	output logic [15:0] mem_rdata // Read data.
);
	logic [15:0] mem [0:16383]; // Table words.
	logic [15:0] last_reg; // Last word read.
	logic [1:0] wait_reg; // Cycles waited.
	// Fill the table with a marker so that missed writes show.
	initial begin
		last_reg = 16'h0000;
		for (int i = 0; i < 16384; i++) begin
			mem[i] = 16'hFFA5;
		end
	end
	// Idle data is inverted so a read outside a grant is caught.
	assign mem_rdata = mem_grant ? mem[mem_addr] : ~last_reg;
	// Grant one cycle after the request, or four when slow.
	always @(posedge ref_clk) begin
		if (rst || !mem_req || mem_grant) begin
			wait_reg <= 2'h0;
			mem_grant <= 1'h0;
		end else begin
			wait_reg <= wait_reg + 2'h1;
			mem_grant <= !slow || wait_reg == 2'h3;
		end
		if (mem_req && mem_grant) begin
			last_reg <= mem[mem_addr];
			if (mem_we) begin
				mem[mem_addr] <= mem_wdata;
			end
		end
	end
endmodule

// *** test/test_amta_top.sv ***
`timescale 1ns/100ps
module test_amta_top
	import amta_pkg::*;
;
	logic ref_clk = 1'h0, rst = 1'h1, slow = 1'h0, fmt_on = 1'h1; // Controls.
	logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0; // Bus.
	logic hv = 1'h0; // Hit pulse.
	logic [7:0] awa = 8'h00, ara = 8'h00; // Register addresses.
	logic [31:0] wd = 32'h0, rd, v; // Bus data.
	logic [11:0] he = 12'h0, ep = 12'hFFF; // Hit entry, next wipe entry.
	logic awr, wr_r, bv, arr, rv, req, we, gnt, tick; // Outputs.
	logic [1:0] br, rr, rsp; // Answer codes.
	logic [13:0] ma; // Table address.
	logic [15:0] mwd, mrd; // Table data.
	int fails = 0, checks_done = 0, n_wr = 0, k; // Counters.
	longint t0, t1; // Pulse edges.
	amta_top #(.PRESC_BITS(2)) uut (.ref_clk, .rst,
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .mem_req(req), .mem_we(we),
		.mem_addr(ma), .mem_wdata(mwd), .mem_grant(gnt), .mem_rdata(mrd),
		.hit_valid(hv), .hit_entry(he), .age_tick_pulse(tick));
	amta_bmu_model bmu (.ref_clk, .rst, .mem_req(req), .mem_we(we),
		.mem_addr(ma), .mem_wdata(mwd), .slow, .mem_grant(gnt),
		.mem_rdata(mrd));
	// ****************************************
	// Checking and bus tasks
	// ****************************************
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Write one word; each channel is released when it is taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		awv <= 1'h1; awa <= a; wv <= 1'h1; wd <= d; bre <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (awr) awv <= 1'h0;
			if (wr_r) wv <= 1'h0;
		end while (!bv);
		rsp = br;
		bre <= 1'h0;
	endtask
	task automatic rd_(input logic [7:0] a);
		@(posedge ref_clk);
		arv <= 1'h1; ara <= a; rre <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (arr) arv <= 1'h0;
		end while (!rv);
		v = rd; rsp = rr;
		rre <= 1'h0;
	endtask
	task automatic wait_clear(input int b);
		do rd_(OFS_STATUS); while (v[b] !== 1'h0);
	endtask
	// Every format write must hit the next entry down with zero.
	always @(posedge ref_clk) begin
		if (fmt_on && req && gnt && we) begin
			chk({2'h0, ma, mwd}, {2'h0, ep, WORD_FIRST, 16'h0});
			ep = ep - 12'h1;
			n_wr++;
		end
	end
	initial begin
		repeat (95000) @(posedge ref_clk);
		fails++;
		print_verdict();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		rd_(OFS_CTRL);
		chk(v, {24'h0, CTRL_RST});
		rd_(OFS_PERIOD);
		chk(v, {12'h0, PERIOD_RST});
		wr(OFS_CTRL, 32'h80);
		rd_(8'h0C);
		chk(rsp, RESP_SLVERR);
		wr(OFS_STATUS, 32'h0);
		chk(rsp, RESP_SLVERR);
		wait_clear(0);
		chk(n_wr, 4096);
		// Abort a slow pass part way, then restart it.
		for (int i = 0; i < 4096; i++) bmu.mem[4*i] = 16'h1111;
		ep = 12'hFFF; n_wr = 0; slow <= 1'h1;
		wr(OFS_CTRL, 32'h81);
		repeat (100) @(posedge ref_clk);
		wr(OFS_CTRL, 32'h00);
		repeat (5) @(posedge ref_clk);
		k = n_wr;
		repeat (80) @(posedge ref_clk);
		chk(n_wr, k);
		chk(bmu.mem[0], 16'h1111);
		ep = 12'hFFF; n_wr = 0; slow <= 1'h0;
		wr(OFS_CTRL, 32'h81);
		wait_clear(0);
		chk(n_wr, 4096);
		chk(bmu.mem[0], 16'h0);
		// One aging pass over hand-made entries.
		fmt_on = 1'h0;
		bmu.mem[20] = 16'h3ABC; bmu.mem[22] = 16'h01A5;
		bmu.mem[26] = 16'hC0A5; bmu.mem[30] = 16'hC1A5;
		bmu.mem[34] = 16'h00A5; bmu.mem[38] = 16'h50A5;
		wr(OFS_PERIOD, 32'h8);
		wr(OFS_CTRL, 32'h88);
		@(posedge tick); t0 = $time;
		@(negedge tick); t1 = $time;
		chk(t1 - t0, 120);
		@(posedge tick); t1 = $time;
		chk(t1 - t0, 8 * 4 * 8);
		wr(OFS_PERIOD, 32'hFFFFF);
		wait_clear(1);
		chk(bmu.mem[22], 16'h00A5);
		chk(bmu.mem[20], 16'h0ABC);
		chk(bmu.mem[26], 16'hBFA5);
		chk(bmu.mem[30], 16'hC1A5);
		chk(bmu.mem[34], 16'h00A5);
		// Aging off: no trigger or table traffic, but a hit still reloads.
		wr(OFS_CTRL, 32'h80); wr(OFS_PERIOD, 32'h2);
		k = 0;
		repeat (100) @(posedge ref_clk) k += tick | req;
		chk(k, 0);
		hv <= 1'h1; he <= 12'h009;
		@(posedge ref_clk) hv <= 1'h0;
		repeat (20) @(posedge ref_clk);
		chk(bmu.mem[38], 16'hBFA5);
		print_verdict();
	end
endmodule
